// >>> hw/secondary_tx_slot_mapper.sv
`timescale 1ns/1ps
module secondary_tx_slot_mapper #(
  parameter int unsigned WORD_W = slot_mapper_pkg::DEFAULT_WORD_W  // Bits per slot
) (
  input  wire logic                                   clk,            // System clock
  input  wire logic                                   reset,          // Sync reset, high
  input  wire logic                                   psel,           // APB select
  input  wire logic                                   penable,        // APB access phase
  input  wire logic                                   pwrite,         // APB write
  input  wire logic [slot_mapper_pkg::APB_ADDR_W-1:0] paddr,          // APB byte address
  input  wire logic [slot_mapper_pkg::APB_DATA_W-1:0] pwdata,         // APB write data
  input  wire logic [3:0]                             pstrb,          // APB byte strobes
  output logic      [slot_mapper_pkg::APB_DATA_W-1:0] prdata,         // APB read data
  output logic                                        pready,         // APB ready
  output logic                                        pslverr,        // APB error
  input  wire logic [WORD_W-1:0]                      adc1_sample,    // ADC channel 1 word
  input  wire logic [WORD_W-1:0]                      adc2_sample,    // ADC channel 2 word
  input  wire logic [WORD_W-1:0]                      adc3_sample,    // ADC channel 3 word
  input  wire logic [WORD_W-1:0]                      battery_sample, // Battery voltage word
  input  wire logic                                   bit_clk,        // Link bit clock
  input  wire logic                                   frame_sync,     // Link frame sync
  output logic                                        primary_serial_out, // Primary data
  output logic                                        primary_serial_oe,  // Primary enable
  output logic                                        second_serial_out,  // Second data
  output logic                                        second_serial_oe    // Second enable
);
  import slot_mapper_pkg::*;

  localparam int unsigned WORD_SHIFT = $clog2(WORD_W);  // Bit index width in a slot
  localparam int unsigned POS_W      = WORD_SHIFT + 6;  // Covers 32 slots and spare
  localparam logic [POS_W-1:0] POS_MAX = '1;            // Counter saturation value

  // Bus-side registers
  logic [7:0]            ch_reg [NUM_CHAN];   // Channel source and slot
  logic [7:0]            pinsel_reg;          // Pin-select bits
  logic [1:0]            format_reg;          // Frame format
  logic [APB_DATA_W-1:0] prdata_reg;          // Read data captured in setup
  logic [APB_DATA_W-1:0] rd_value;            // Decoded read value
  logic                  mapped;              // Address hits a register
  logic                  wr_en;               // Write takes effect this edge

  // Crossing, bus side
  logic [7:0]        hold_ch [NUM_CHAN];      // Held channel settings
  logic [2:0]        hold_pin;                // Held pin selects
  logic [1:0]        hold_fmt;                // Held format
  logic [WORD_W-1:0] hold_word [NUM_CHAN+1];  // Held samples, battery last
  logic              req_reg;                 // Request toggle
  logic              ack_s1, ack_s2, ack_s3;  // Acknowledge synchroniser
  logic              hs_idle;                 // Previous hand-over done

  // Crossing and framing, link side
  logic              lrst_s1, lrst_s2, lrst_s3; // Reset synchroniser
  logic              link_reset;              // Reset in link domain
  logic              req_s1, req_s2, req_s3;  // Request synchroniser
  logic              ack_reg;                 // Acknowledge toggle
  logic [7:0]        snap_ch [NUM_CHAN];      // Active channel settings
  logic [2:0]        snap_pin;                // Active pin selects
  fmt_e              snap_fmt;                // Active format
  logic [WORD_W-1:0] snap_word [NUM_CHAN+1];  // Active samples
  logic              fs_q;                    // Last frame sync level
  logic [POS_W-1:0]  cnt_reg, cnt_next;       // Bit count in frame or half
  logic              half_reg, half_next;     // Right half flag
  logic              framed_reg, framed_next; // A frame has started
  logic              left_edge, right_edge;   // Frame and half start
  logic              active;                  // A data bit position
  logic [POS_W-1:0]  bitpos;                  // Data bit after delay
  logic [5:0]        key;                     // Current slot as field value
  logic              half_sel;                // Half used for the slot key
  logic              key_ok;                  // Slot lies inside frame
  logic [NUM_CHAN-1:0] hit;                   // Channel slot is current
  logic [NUM_CHAN-1:0] src_on;                // Channel has a data source
  logic [NUM_CHAN-1:0] drive;                 // Channel drives this bit
  logic [NUM_CHAN-1:0] ch_bit;                // Bit each channel would send
  logic              prim_out_next, prim_oe_next; // Primary next values
  logic              sec_out_next, sec_oe_next;   // Second next values

  // APB handshake; zero wait states
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_reg;
  assign wr_en   = psel & penable & pwrite & mapped & pstrb[0];

  // Address decode and read mux; reserved bits read zero
  always_comb begin
    rd_value = '0;
    mapped   = 1'b1;
    case (paddr)
      CH1_ADDR:    rd_value = {24'h0, ch_reg[0]};
      CH2_ADDR:    rd_value = {24'h0, ch_reg[1]};
      CH3_ADDR:    rd_value = {24'h0, ch_reg[2]};
      PINSEL_ADDR: rd_value = {24'h0, pinsel_reg};
      FORMAT_ADDR: rd_value = {30'h0, format_reg};
      default:     mapped   = 1'b0;  // Unmapped: error, reads zero
    endcase
  end

  // Read data latched in setup, shown in access
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_reg <= '0;
    end else if (psel && !penable) begin
      prdata_reg <= rd_value;
    end
  end

  // Register writes; reserved bits masked off
  always_ff @(posedge clk) begin
    if (reset) begin
      ch_reg[0]  <= CH1_RESET;
      ch_reg[1]  <= CH2_RESET;
      ch_reg[2]  <= CH3_RESET;
      pinsel_reg <= PINSEL_RESET;
      format_reg <= FORMAT_RESET[1:0];
    end else if (wr_en) begin
      case (paddr)
        CH1_ADDR:    ch_reg[0]  <= pwdata[7:0] & CH12_MASK;
        CH2_ADDR:    ch_reg[1]  <= pwdata[7:0] & CH12_MASK;
        CH3_ADDR:    ch_reg[2]  <= pwdata[7:0] & CH3_MASK;
        PINSEL_ADDR: pinsel_reg <= pwdata[7:0] & PINSEL_MASK;
        FORMAT_ADDR: format_reg <= pwdata[1:0] & FORMAT_MASK[1:0];
        default:     ;  // Never reached, wr_en needs a hit
      endcase
    end
  end

  chk_reset_values: assert property (@(posedge clk)
    reset |=> (ch_reg[0] == 8'h00 && ch_reg[1] == 8'h01 && ch_reg[2] == 8'h02))
    else $error("channel registers not at reset values");

  // Acknowledge synchroniser, bus side
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
    end else begin
      ack_s1 <= ack_reg;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end

  assign hs_idle = (ack_s2 == ack_s3) && (ack_s3 == req_reg);

  // Hold settings and samples, then toggle the request
  always_ff @(posedge clk) begin
    if (reset) begin
      req_reg <= 1'b0;
      for (int i = 0; i < NUM_CHAN; i++) begin
        hold_ch[i] <= '0;
      end
      for (int i = 0; i <= NUM_CHAN; i++) begin
        hold_word[i] <= '0;
      end
      hold_pin <= '0;
      hold_fmt <= '0;
    end else if (hs_idle) begin
      req_reg      <= ~req_reg;
      hold_ch[0]   <= ch_reg[0];
      hold_ch[1]   <= ch_reg[1];
      hold_ch[2]   <= ch_reg[2];
      hold_pin     <= pinsel_reg[2:0];
      hold_fmt     <= format_reg;
      hold_word[0] <= adc1_sample;
      hold_word[1] <= adc2_sample;
      hold_word[2] <= adc3_sample;
      hold_word[3] <= battery_sample;
    end
  end

  // Reset synchroniser into the link domain
  always_ff @(posedge bit_clk) begin
    lrst_s1 <= reset;
    lrst_s2 <= lrst_s1;
    lrst_s3 <= lrst_s2;
    if (lrst_s2 == lrst_s3) begin
      link_reset <= lrst_s3;
    end
  end

  // Request synchroniser, link side
  always_ff @(posedge bit_clk) begin
    if (link_reset) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= req_reg;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // Take the held bundle once the request settles
  always_ff @(posedge bit_clk) begin
    if (link_reset) begin
      ack_reg  <= 1'b0;
      snap_ch[0] <= CH1_RESET;
      snap_ch[1] <= CH2_RESET;
      snap_ch[2] <= CH3_RESET;
      snap_pin <= PINSEL_RESET[2:0];
      snap_fmt <= FMT_TDM;
      for (int i = 0; i <= NUM_CHAN; i++) begin
        snap_word[i] <= '0;
      end
    end else if (req_s2 == req_s3 && req_s3 != ack_reg) begin
      ack_reg  <= req_s3;
      snap_ch  <= hold_ch;
      snap_pin <= hold_pin;
      snap_fmt <= (hold_fmt == 2'h3) ? FMT_TDM : fmt_e'(hold_fmt);  // Code 3 runs as TDM
      snap_word <= hold_word;
    end
  end

  // Frame edges; I2S starts the left half on the falling edge
  always_comb begin
    left_edge  = (snap_fmt == FMT_I2S) ? (fs_q & ~frame_sync) : (frame_sync & ~fs_q);
    right_edge = (snap_fmt == FMT_I2S) ? (frame_sync & ~fs_q) : (fs_q & ~frame_sync);
    if (snap_fmt == FMT_TDM) begin
      right_edge = 1'b0;  // TDM has one run of slots
    end
    cnt_next    = (cnt_reg == POS_MAX) ? cnt_reg : cnt_reg + 1'b1;
    half_next   = half_reg;
    framed_next = framed_reg | left_edge;
    if (left_edge) begin
      cnt_next  = '0;
      half_next = 1'b0;
    end else if (right_edge) begin
      cnt_next  = '0;
      half_next = 1'b1;
    end
  end

  // Slot position; I2S data lags its edge by one bit
  always_comb begin
    active   = framed_next && (cnt_next != POS_MAX);
    bitpos   = cnt_next;
    half_sel = half_next;
    if (snap_fmt == FMT_I2S) begin
      active   = framed_reg && (cnt_reg != POS_MAX);  // Last bit of a half meets the next edge
      bitpos   = cnt_reg;
      half_sel = half_reg;
    end
    if (snap_fmt == FMT_TDM) begin
      key_ok = (bitpos >> WORD_SHIFT) < TDM_SLOTS;
      key    = {1'b0, bitpos[WORD_SHIFT +: SLOT_W]};
    end else begin
      key_ok = (bitpos >> WORD_SHIFT) < HALF_SLOTS;
      key    = {1'b0, half_sel, bitpos[WORD_SHIFT +: 4]};
    end
  end

  // Per-channel source decode and slot match
  always_comb begin
    src_on[0] = snap_ch[0][SRC_LSB];
    src_on[1] = snap_ch[1][SRC_LSB];
    src_on[2] = (snap_ch[2][SRC_LSB +: 2] == SRC_ADC) ||
                (snap_ch[2][SRC_LSB +: 2] == SRC_BATTERY);
    for (int i = 0; i < NUM_CHAN; i++) begin
      hit[i]    = active && key_ok && (key == {1'b0, snap_ch[i][SLOT_LSB +: SLOT_W]});
      ch_bit[i] = snap_word[i][WORD_W-1-bitpos[WORD_SHIFT-1:0]];
      drive[i]  = hit[i] && src_on[i];
    end
    if (snap_ch[2][SRC_LSB +: 2] == SRC_BATTERY) begin
      ch_bit[2] = snap_word[NUM_CHAN][WORD_W-1-bitpos[WORD_SHIFT-1:0]];
    end
  end

  // Route each driving channel to its selected pin
  always_comb begin
    prim_out_next = 1'b0;
    prim_oe_next  = 1'b0;
    sec_out_next  = 1'b0;
    sec_oe_next   = 1'b0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (drive[i] && snap_pin[i]) begin
        sec_oe_next  = 1'b1;
        sec_out_next = sec_out_next | ch_bit[i];
      end else if (drive[i]) begin
        prim_oe_next  = 1'b1;
        prim_out_next = prim_out_next | ch_bit[i];
      end
    end
  end

  // Framing state and registered pin outputs
  always_ff @(posedge bit_clk) begin
    if (link_reset) begin
      fs_q               <= 1'b0;
      cnt_reg            <= POS_MAX;
      half_reg           <= 1'b0;
      framed_reg         <= 1'b0;
      primary_serial_out <= 1'b0;
      primary_serial_oe  <= 1'b0;
      second_serial_out  <= 1'b0;
      second_serial_oe   <= 1'b0;
    end else begin
      fs_q               <= frame_sync;
      cnt_reg            <= cnt_next;
      half_reg           <= half_next;
      framed_reg         <= framed_next;
      primary_serial_out <= prim_out_next;
      primary_serial_oe  <= prim_oe_next;
      second_serial_out  <= sec_out_next;
      second_serial_oe   <= sec_oe_next;
    end
  end

  chk_ch1_data_out: assert property (@(posedge bit_clk) disable iff (link_reset)
    (drive == 3'b001 && !snap_pin[0]) |=>
      (primary_serial_oe && primary_serial_out == $past(ch_bit[0])))
    else $error("channel 1 bit not on primary output");
  chk_ch1_off_release: assert property (@(posedge bit_clk) disable iff (link_reset)
    (hit[0] && !snap_ch[0][SRC_LSB] && !hit[1] && !hit[2]) |=>
      (!primary_serial_oe && !second_serial_oe))
    else $error("tri-stated channel 1 drove a pin");
  chk_ch2_second_pin: assert property (@(posedge bit_clk) disable iff (link_reset)
    (drive == 3'b010 && snap_pin[1]) |=>
      (second_serial_oe && !primary_serial_oe && second_serial_out == $past(ch_bit[1])))
    else $error("channel 2 bit not on second output");
  chk_ch3_reserved: assert property (@(posedge bit_clk) disable iff (link_reset)
    (hit[2] && snap_ch[2][6:5] == 2'h3 && !hit[0] && !hit[1]) |=>
      (!primary_serial_oe && !second_serial_oe))
    else $error("reserved channel 3 source drove a pin");
  chk_tdm_first_slot: assert property (@(posedge bit_clk) disable iff (link_reset)
    (left_edge && snap_fmt == FMT_TDM && snap_ch[0][4:0] == 5'h00 && src_on[0] &&
     !snap_pin[0]) |=> primary_serial_oe)
    else $error("TDM slot 0 not driven at frame start");
  chk_half_select: assert property (@(posedge bit_clk) disable iff (link_reset)
    (snap_fmt != FMT_TDM && hit[0]) |-> (half_sel == snap_ch[0][HALF_BIT]))
    else $error("channel driven in the wrong half");
  chk_pin_select: assert property (@(posedge bit_clk) disable iff (link_reset)
    (drive == 3'b001 && snap_pin[0]) |=> (second_serial_oe && !primary_serial_oe))
    else $error("pin select ignored");
  chk_idle_release: assert property (@(posedge bit_clk) disable iff (link_reset)
    (drive == 3'b000) |=> (!primary_serial_oe && !second_serial_oe))
    else $error("line driven with no channel active");
endmodule

// >>> hw/slot_mapper_pkg.sv
package slot_mapper_pkg;

  // Bus geometry
  localparam int unsigned APB_ADDR_W = 12;  // Byte address width
  localparam int unsigned APB_DATA_W = 32;  // Data width

  // Register indices; byte address is four times the index
  localparam logic [7:0] PINSEL_IDX = 8'h1d;  // Pin-select bits of channels 1 to 3
  localparam logic [7:0] CH1_IDX    = 8'h1e;  // Channel 1 source and slot
  localparam logic [7:0] CH2_IDX    = 8'h1f;  // Channel 2 source and slot
  localparam logic [7:0] CH3_IDX    = 8'h20;  // Channel 3 source and slot
  localparam logic [7:0] FORMAT_IDX = 8'h10;  // Frame format select

  // Byte addresses
  localparam logic [APB_ADDR_W-1:0] PINSEL_ADDR = {2'h0, PINSEL_IDX, 2'h0};
  localparam logic [APB_ADDR_W-1:0] CH1_ADDR    = {2'h0, CH1_IDX, 2'h0};
  localparam logic [APB_ADDR_W-1:0] CH2_ADDR    = {2'h0, CH2_IDX, 2'h0};
  localparam logic [APB_ADDR_W-1:0] CH3_ADDR    = {2'h0, CH3_IDX, 2'h0};
  localparam logic [APB_ADDR_W-1:0] FORMAT_ADDR = {2'h0, FORMAT_IDX, 2'h0};

  // Field layout
  localparam int unsigned SLOT_LSB  = 0;  // Slot field low bit
  localparam int unsigned SLOT_W    = 5;  // Slot field width
  localparam int unsigned SRC_LSB   = 5;  // Source field low bit
  localparam int unsigned HALF_BIT  = 4;  // Slot bit that picks the right half
  localparam int unsigned HALF_SLOTS = 16; // Slots per half in half formats
  localparam int unsigned TDM_SLOTS = 32; // Slots per TDM frame

  // Writable bit masks; reserved bits stay zero
  localparam logic [7:0] CH12_MASK   = 8'h3f;  // Source bit 5, slot 4:0
  localparam logic [7:0] CH3_MASK    = 8'h7f;  // Source 6:5, slot 4:0
  localparam logic [7:0] PINSEL_MASK = 8'h07;  // One bit per channel
  localparam logic [7:0] FORMAT_MASK = 8'h03;  // Format code

  // Reset values
  localparam logic [7:0] CH1_RESET    = 8'h00;  // Tri-state, slot 0
  localparam logic [7:0] CH2_RESET    = 8'h01;  // Tri-state, slot 1
  localparam logic [7:0] CH3_RESET    = 8'h02;  // Tri-state, slot 2
  localparam logic [7:0] PINSEL_RESET = 8'h00;  // All on primary output
  localparam logic [7:0] FORMAT_RESET = 8'h00;  // TDM

  // Channel 3 source codes
  localparam logic [1:0] SRC_TRISTATE = 2'h0;  // Line released
  localparam logic [1:0] SRC_ADC      = 2'h1;  // ADC channel data
  localparam logic [1:0] SRC_BATTERY  = 2'h2;  // Battery voltage data

  // Frame formats
  typedef enum logic [1:0] {
    FMT_TDM            = 2'b00,
    FMT_I2S            = 2'b01,
    FMT_LEFT_JUSTIFIED = 2'b10
  } fmt_e;

  localparam int unsigned DEFAULT_WORD_W = 32;  // Slot and sample width
  localparam int unsigned NUM_CHAN       = 3;   // Channels handled here

endpackage

// >>> tb/frame_host_model.sv
`timescale 1ns/1ps
// Host end of the link: makes frame sync and samples both data lines
module frame_host_model #(
  parameter int W = 16  // Bits per slot
) (
  input  wire logic bit_clk,     // Link bit clock
  output logic      frame_sync,  // Frame sync to the port
  input  wire logic pri_out,     // Primary data
  input  wire logic pri_oe,      // Primary enable
  input  wire logic sec_out,     // Second data
  input  wire logic sec_oe       // Second enable
);
  logic lvl  [2][1024];  // Line level per pin and bit
  logic en   [2][1024];  // Driven flag per pin and bit
  logic last [2];        // Last level seen per pin

  initial frame_sync = 1'b0;
  initial last = '{1'b0, 1'b0};

  // Sample both lines; a released line shows the inverse of its last level
  task automatic grab(input int i);
    en[0][i] = pri_oe;
    en[1][i] = sec_oe;
    lvl[0][i] = pri_oe ? pri_out : !last[0];
    lvl[1][i] = sec_oe ? sec_out : !last[1];
    last[0] = lvl[0][i];
    last[1] = lvl[1][i];
  endtask

  // One frame of n slots per half; sync moves on falling edges only
  task automatic frame(input int fmt, input int n);
    int two;
    int d;
    int nb;
    two = (fmt == 1 || fmt == 2);
    d = (fmt == 1);
    nb = n * W;
    @(negedge bit_clk);
    frame_sync <= d[0];  // Idle level before the frame edge
    @(negedge bit_clk);
    frame_sync <= !d[0];  // Level that marks the frame start
    for (int e = 0; e < nb * (1 + two) + d; e++) begin
      @(negedge bit_clk);
      if (e >= d) grab(e - d);
      if (two == 0) begin
        frame_sync <= 1'b0;  // Short pulse in TDM
      end else if (e == nb - 1) begin
        frame_sync <= d[0];  // Switch to the right half
      end
    end
  endtask
endmodule

// >>> tb/test_secondary_tx_slot_mapper.sv
`timescale 1ns/1ps
module test_secondary_tx_slot_mapper;
  import slot_mapper_pkg::*;
  localparam int W = 16;  // Shortened slot width
  logic              clk, reset, psel, penable, pwrite;  // Bus side
  logic [11:0]       paddr;        // Byte address
  logic [31:0]       pwdata;       // Write data
  logic [31:0]       prdata;       // Read data
  logic              pready;       // Ready
  logic              pslverr;      // Error
  logic [W-1:0]      smp [4];      // Sample words: adc1..3, battery
  logic              bit_clk;      // Link clock
  logic              frame_sync;   // From host model
  logic              po, poe, so, soe;  // Pin data and enables
  logic [31:0]       seed;         // Random state
  int                n_errors;     // Mismatches
  int                num_checks;   // Comparisons

  secondary_tx_slot_mapper #(.WORD_W(W)) uut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc1_sample(smp[0]), .adc2_sample(smp[1]), .adc3_sample(smp[2]),
    .battery_sample(smp[3]), .bit_clk(bit_clk), .frame_sync(frame_sync),
    .primary_serial_out(po), .primary_serial_oe(poe),
    .second_serial_out(so), .second_serial_oe(soe));

  frame_host_model #(.W(W)) host (
    .bit_clk(bit_clk), .frame_sync(frame_sync),
    .pri_out(po), .pri_oe(poe), .sec_out(so), .sec_oe(soe));

  // System clock, 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Link clock, 160 ns, unrelated phase; runs through reset for the crossing
  initial begin
    bit_clk = 1'b0;
    #37;
    forever #80 bit_clk = ~bit_clk;
  end

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Compare one result word
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; request held until pready is seen high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) n_errors++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Configure, settle, capture one frame and compare every slot
  task automatic scen(input int f, input int n, input int c1, input int c2,
                      input int c3, input int pm);
    logic [31:0] q, r, gw, go, ew, eo;
    logic        e;
    int          cfg [3];
    int          src, sl, k;
    cfg = '{c1, c2, c3};
    apb(FORMAT_ADDR, 1'b1, 32'(f), q, e);
    apb(PINSEL_ADDR, 1'b1, 32'(pm), q, e);
    for (int c = 0; c < 3; c++) apb(CH1_ADDR + 12'(4 * c), 1'b1, 32'(cfg[c]), q, e);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      smp[i] <= r[W-1:0];
    end
    host.frame(f, 1);
    host.frame(f, 1);
    host.frame(f, n);
    for (int p = 0; p < 2; p++) begin
      for (int h = 0; h < 1 + (f == 1 || f == 2); h++) begin
        for (int s = 0; s < n; s++) begin
          ew = 32'h0;
          eo = 32'h0;
          for (int c = 0; c < 3; c++) begin
            src = (cfg[c] >> 5) & (c == 2 ? 3 : 1);
            sl = cfg[c] & 31;
            if (((pm >> c) & 1) == p && (src == 1 || (c == 2 && src == 2)) &&
                ((f == 0 || f == 3) ? (h == 0 && sl == s)
                                    : ((sl >> 4) == h && (sl % 16) == s))) begin
              eo = 32'((64'h1 << W) - 1);
              ew = ew | 32'(src == 2 ? smp[3] : smp[c]);  // Shared slot ORs
            end
          end
          gw = 32'h0;
          go = 32'h0;
          for (int b = 0; b < W; b++) begin
            k = (h * n + s) * W + b;
            gw = {gw[30:0], host.lvl[p][k]};
            go = {go[30:0], host.en[p][k]};
          end
          check(go, eo);
          check(gw & eo, ew);
        end
      end
    end
  endtask

  // Summary and verdict
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #400000;
    n_errors++;
    test_done();
  end

  // Main sequence
  initial begin
    logic [31:0] q;
    logic        e;
    n_errors = 0;
    num_checks = 0;
    seed = 32'hbe215035;
    reset = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    smp = '{default: '0};
    repeat (200) @(posedge clk);  // Long enough for the link side reset
    reset <= 1'b0;
    @(posedge clk);
    for (int c = 0; c < 3; c++) begin
      apb(CH1_ADDR + 12'(4 * c), 1'b0, 32'h0, q, e);
      check(q, 32'(c));
    end
    apb(12'h004, 1'b0, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    apb(CH3_ADDR, 1'b1, 32'h5f, q, e);
    apb(CH3_ADDR, 1'b0, 32'h0, q, e);
    check(q, 32'h5f);
    scen(0, 4, 'h23, 'h22, 'h41, 'b010);
    scen(0, 4, 'h01, 'h02, 'h63, 'b111);
    scen(1, 2, 'h30, 'h21, 'h31, 'b100);
    scen(2, 2, 'h20, 'h31, 'h50, 'b011);
    scen(3, 2, 'h20, 'h21, 'h21, 'b000);
    scen(0, 32, 'h3f, 'h3e, 'h40, 'b010);
    test_done();
  end
endmodule
